// ---- rtl/sbw_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the link upkeep block
// Assumes: 125 MHz system clock, link clock of 160 ns period
// Notes: Definitions only
`ifndef SBW_CONSTS_SVH
`define SBW_CONSTS_SVH

// Register offsets
`define SBW_REG_GEN_CFG 8'h01
`define SBW_REG_BC_MODE 8'h26
`define SBW_REG_BC_CFG 8'h27
`define SBW_REG_STATUS 8'h1c
`define SBW_REG_ERR_CNT 8'h1d

// Field positions in the general configuration register
`define SBW_BIT_RX_EDGE 0
`define SBW_BIT_TX_EDGE 1
`define SBW_BIT_WAKE 2
`define SBW_BIT_OSS 4

// Field positions in the status register
`define SBW_ST_PASS 0
`define SBW_ST_LOCK 1
`define SBW_ST_SER_ACTIVE 2
`define SBW_ST_OVERFLOW 3
`define SBW_ST_TESTING 4

// Reset values and special values
`define SBW_GEN_CFG_RST 8'h03
`define SBW_BC_MODE_RST 8'h00
`define SBW_BC_CFG_RST 8'h00
`define SBW_BC_WAKE_MODE 8'hc0
`define SBW_PRBS_SEED 15'h7fff

// Timing
`define SBW_CLK_NS 8
`define SBW_LINK_HALF_NS 80
`define SBW_HALF_CYC ((`SBW_LINK_HALF_NS) / (`SBW_CLK_NS))
`define SBW_LOSS_NS 800
`define SBW_LOSS_CYC ((`SBW_LOSS_NS) / (`SBW_CLK_NS))
`define SBW_LOCK_EDGES 64

`endif

// ---- rtl/sbw_pkg.sv ----
// Purpose: Types shared by the link upkeep block and its bench
// Assumes: Nothing
// Notes: Constants live in sbw_consts.svh
package sbw_pkg;
   // Serializer power state
   typedef enum logic [0:0] {
      SER_STANDBY = 1'b0,
      SER_ACTIVE = 1'b1
   } sbw_ser_state_type;

   // Result pin pulse sequencer
   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_LOW1 = 2'b01,
      PS_HIGH = 2'b10,
      PS_LOW2 = 2'b11
   } sbw_pulse_state_type;

   // Self-test oscillator choice on the two select pins
   typedef enum logic [1:0] {
      OSC_EXTERNAL = 2'b00,
      OSC_50MHZ = 2'b01,
      OSC_25MHZ = 2'b10,
      OSC_12M5 = 2'b11
   } sbw_osc_sel_type;
endpackage

// ---- rtl/sbw_link_maint.sv ----
// Purpose: Self test, remote wake, auto power-down and edge select of a serial link pair
// Assumes: Link clock and pins are asynchronous to I_SYS_CLK; I_NRST is the power-down bar pin
// Notes: Registers reached over a simple byte port; read data one cycle after the address
`timescale 1ns/100ps
`include "sbw_consts.svh"

// Behaviour
// - Select code 00 requests external pixel clock
// - Codes 01,10,11 pick internal oscillator rates
// - Self test only in camera configuration
// - Test enable sends start command to serializer
// - Check each payload against pseudo-random sequence
// - Failing payload drops result half a cycle
// - Multi-bit failure toggles result low-high-low
// - Readable accumulated error count register
// - Serializer pin 0 shows pass flag
// - Count errors only with enable and lock
// - Result retained; reads high after reset
// - Serializer sleeps until wake signal arrives
// - Active serializer prefers pixel clock, else oscillator
// - Wake only in camera configuration
// - Clearing wake bit returns serializer standby
// - Auto mode falls back to oscillator, relocks
// - Powered-down serial driver held static high
// - Stream loss powers down; restart relocks
// - Sleep output enable follows output state select; strobe held low
// - Edge select bits choose latch/strobe edge
module sbw_link_maint #(
   parameter int DATA_W = 16,
   parameter int CNT_W = 8
) (
   input wire logic I_SYS_CLK,
   input wire logic I_NRST,
   input wire logic I_DES_MODE,
   input wire logic I_SER_MODE,
   input wire logic I_SER_PDB,
   input wire logic I_SELF_TEST_ENABLE_PIN,
   input wire logic [1:0] I_OSC_SEL_PIN,
   input wire logic I_LINK_CLK,
   input wire logic [DATA_W-1:0] I_LINK_DATA,
   input wire logic I_SER_PCLK,
   input wire logic [7:0] I_REG_ADDR,
   input wire logic I_REG_WR,
   input wire logic [7:0] I_REG_WDATA,
   input wire logic I_RX_READY,
   output logic [7:0] O_REG_RDATA,
   output logic O_LOCK,
   output logic O_PASS,
   output logic O_BIST_CMD,
   output sbw_pkg::sbw_osc_sel_type O_BIST_OSC,
   output logic O_EXT_PCLK_REQ,
   output logic O_WAKE_SIGNAL,
   output logic [DATA_W-1:0] O_RX_DATA,
   output logic O_RX_VALID,
   output logic O_RX_OE,
   output logic O_RX_STROBE,
   output logic O_SER_ACTIVE,
   output logic O_SER_CLK_FROM_PCLK,
   output logic O_SER_TX_STATIC_HIGH,
   output logic O_SER_LATCH_RISE,
   output logic O_SER_GPIO0_OUT,
   output logic O_SER_GPIO0_OE
);
   import sbw_pkg::*;

   localparam logic [4:0] HALF_CYC = 5'(`SBW_HALF_CYC);
   localparam logic [7:0] LOSS_CYC = 8'(`SBW_LOSS_CYC);
   localparam logic [6:0] LOCK_EDGES = 7'(`SBW_LOCK_EDGES);
   localparam int NSYNC = 7 + DATA_W;

   // Two-stage synchronisers for the mode, power-down, enable, select and link pins; stage one is read by stage two only
   logic [NSYNC-1:0] sync1_q, sync2_q;
   logic [NSYNC-1:0] pins_raw;
   assign pins_raw = {I_DES_MODE, I_SER_MODE, I_SER_PDB, I_SELF_TEST_ENABLE_PIN,
                      I_OSC_SEL_PIN, I_LINK_CLK, I_LINK_DATA};

   // Synchroniser chain
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   logic des_camera, ser_camera, ser_pdb, ste, link_clk;
   logic [1:0] osc_sel;
   logic [DATA_W-1:0] link_data;
   assign des_camera = sync2_q[NSYNC-1];
   assign ser_camera = ~sync2_q[NSYNC-2];
   assign ser_pdb = sync2_q[NSYNC-3];
   assign ste = sync2_q[NSYNC-4];
   assign osc_sel = sync2_q[NSYNC-5 -: 2];
   assign link_clk = sync2_q[DATA_W];
   assign link_data = sync2_q[DATA_W-1:0];

   // Pixel clock presence uses its own chain of three flops
   logic pclk1_q, pclk2_q, pclk3_q;
   // Edge history for link clock and test enable
   logic link_prev_q, ste_prev_q;

   // Edge history
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         pclk1_q <= 1'b0;
         pclk2_q <= 1'b0;
         pclk3_q <= 1'b0;
         link_prev_q <= 1'b0;
         ste_prev_q <= 1'b0;
      end else begin
         pclk1_q <= I_SER_PCLK;
         pclk2_q <= pclk1_q;
         pclk3_q <= pclk2_q;
         link_prev_q <= link_clk;
         ste_prev_q <= ste;
      end
   end

   logic link_rise, pclk_edge, session_start, bist_req;
   assign link_rise = link_clk & ~link_prev_q;
   assign pclk_edge = pclk2_q ^ pclk3_q;
   assign bist_req = ste & des_camera;
   assign session_start = bist_req & ~ste_prev_q;

   // Registers written by software
   logic [7:0] gen_cfg_q, bc_mode_q, bc_cfg_q;

   // Register writes; other offsets are ignored
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         gen_cfg_q <= `SBW_GEN_CFG_RST;
         bc_mode_q <= `SBW_BC_MODE_RST;
         bc_cfg_q <= `SBW_BC_CFG_RST;
      end else if (I_REG_WR) begin
         case (I_REG_ADDR)
            `SBW_REG_GEN_CFG: gen_cfg_q <= I_REG_WDATA;
            `SBW_REG_BC_MODE: bc_mode_q <= I_REG_WDATA;
            `SBW_REG_BC_CFG: bc_cfg_q <= I_REG_WDATA;
            default: begin
            end
         endcase
      end
   end

   // Lock tracking on the incoming stream
   logic [7:0] gap_q;
   logic [6:0] edges_q;
   logic lock_q;

   // Stream loss drops lock and powers down; edges relock
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         gap_q <= '0;
         edges_q <= '0;
         lock_q <= 1'b0;
      end else if (link_rise) begin
         gap_q <= '0;
         if (edges_q != LOCK_EDGES) begin
            edges_q <= edges_q + 7'd1;
         end else begin
            lock_q <= 1'b1;
         end
      end else if (gap_q == LOSS_CYC) begin
         // Stream stopped: a restart relocks from scratch
         edges_q <= '0;
         lock_q <= 1'b0;
      end else begin
         gap_q <= gap_q + 8'd1;
      end
   end

   // Expected pattern, advanced one payload per link edge
   function automatic logic [14:0] prbs_step(input logic [14:0] s);
      logic [14:0] v;
      v = s;
      for (int i = 0; i < DATA_W; i++) begin
         v = {v[13:0], v[14] ^ v[13]};
      end
      return v;
   endfunction

   logic [14:0] prbs_q;
   logic [CNT_W-1:0] err_cnt_q;
   logic pass_q;
   logic [DATA_W-1:0] diff;
   logic [4:0] bad_bits;
   logic window, bad_payload;

   assign diff = link_data ^ DATA_W'(prbs_q);
   assign window = bist_req & lock_q;
   assign bad_payload = window & link_rise & (diff != '0);

   // Popcount of the mismatching bits
   always_comb begin
      bad_bits = '0;
      for (int i = 0; i < DATA_W; i++) begin
         bad_bits = bad_bits + 5'(diff[i]);
      end
   end

   // Sequence, result and count; a session start wins over a late error
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         prbs_q <= `SBW_PRBS_SEED;
         err_cnt_q <= '0;
         // Result reads high after power-down toggle
         pass_q <= 1'b1;
      end else if (session_start) begin
         prbs_q <= `SBW_PRBS_SEED;
         err_cnt_q <= '0;
         pass_q <= 1'b1;
      end else if (window && link_rise) begin
         prbs_q <= prbs_step(prbs_q);
         if (bad_payload) begin
            pass_q <= 1'b0;
            if (err_cnt_q != '1) begin
               err_cnt_q <= err_cnt_q + CNT_W'(1);
            end
         end
      end
   end

   // Result pin pulse sequencer
   sbw_pulse_state_type ps_q;
   logic [4:0] ph_cnt_q;
   logic multi_q;

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         ps_q <= PS_IDLE;
         ph_cnt_q <= '0;
         multi_q <= 1'b0;
      end else if (bad_payload) begin
         // A new failure restarts the train; pulses never merge
         ps_q <= PS_LOW1;
         ph_cnt_q <= HALF_CYC - 5'd1;
         multi_q <= (bad_bits >= 5'd2);
      end else if (ph_cnt_q != '0) begin
         ph_cnt_q <= ph_cnt_q - 5'd1;
      end else begin
         ph_cnt_q <= HALF_CYC - 5'd1;
         case (ps_q)
            // Multi-bit failure adds high then low half
            PS_LOW1: ps_q <= multi_q ? PS_HIGH : PS_IDLE;
            PS_HIGH: ps_q <= PS_LOW2;
            PS_LOW2: ps_q <= PS_IDLE;
            default: begin
               ps_q <= PS_IDLE;
               ph_cnt_q <= '0;
            end
         endcase
      end
   end

   // Serializer power state and clock source
   sbw_ser_state_type ser_q;
   logic [7:0] pgap_q;
   logic pclk_ok_q, wake_q;

   // Wake driven only in camera configuration with wake driver mode
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= gen_cfg_q[`SBW_BIT_WAKE] & des_camera
                   & (bc_mode_q == `SBW_BC_WAKE_MODE);
      end
   end

   // Wake latched in driver wake mode, kept after the mode returns to normal
   logic wake_held_q;
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         wake_held_q <= 1'b0;
      end else if (!gen_cfg_q[`SBW_BIT_WAKE]) begin
         // Clearing the wake bit releases it
         wake_held_q <= 1'b0;
      end else if (wake_q) begin
         wake_held_q <= 1'b1;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         ser_q <= SER_STANDBY;
      end else begin
         case (ser_q)
            SER_STANDBY: begin
               if (ser_pdb && ser_camera && wake_held_q) begin
                  ser_q <= SER_ACTIVE;
               end
            end
            SER_ACTIVE: begin
               if (!ser_pdb || !wake_held_q) begin
                  ser_q <= SER_STANDBY;
               end
            end
            default: ser_q <= SER_STANDBY;
         endcase
      end
   end

   // Pixel clock watchdog for auto fallback
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         pgap_q <= '0;
         pclk_ok_q <= 1'b0;
      end else if (pclk_edge) begin
         pgap_q <= '0;
         pclk_ok_q <= 1'b1;
      end else if (pgap_q == LOSS_CYC) begin
         pclk_ok_q <= 1'b0;
      end else begin
         pgap_q <= pgap_q + 8'd1;
      end
   end

   // Two-entry buffer in the received data path
   logic [DATA_W-1:0] skid_q;
   logic skid_v_q, ovf_q, in_valid, in_ready;
   // Words leave the link only when locked and outside self test
   assign in_valid = link_rise & lock_q & ~bist_req;
   assign in_ready = ~skid_v_q;

   // Head and skid entries; ready low with the head stalled means the next word would be lost
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_RX_DATA <= '0;
         O_RX_VALID <= 1'b0;
         skid_q <= '0;
         skid_v_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         if (!O_RX_VALID || I_RX_READY) begin
            O_RX_VALID <= skid_v_q | in_valid;
            O_RX_DATA <= skid_v_q ? skid_q : link_data;
            skid_v_q <= skid_v_q & in_valid;
            skid_q <= link_data;
         end else if (in_valid && in_ready) begin
            skid_v_q <= 1'b1;
            skid_q <= link_data;
         end
         // Sticky overflow; the stream itself cannot be stalled
         if (in_valid && !in_ready && O_RX_VALID && !I_RX_READY) begin
            ovf_q <= 1'b1;
         end
      end
   end

   // Pin and status outputs
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_LOCK <= 1'b0;
         O_PASS <= 1'b1;
         O_BIST_CMD <= 1'b0;
         O_BIST_OSC <= OSC_EXTERNAL;
         O_EXT_PCLK_REQ <= 1'b0;
         O_WAKE_SIGNAL <= 1'b0;
         O_RX_OE <= 1'b0;
         O_RX_STROBE <= 1'b0;
         O_SER_ACTIVE <= 1'b0;
         O_SER_CLK_FROM_PCLK <= 1'b0;
         O_SER_TX_STATIC_HIGH <= 1'b1;
         O_SER_LATCH_RISE <= 1'b1;
         O_SER_GPIO0_OUT <= 1'b0;
         O_SER_GPIO0_OE <= 1'b0;
      end else begin
         O_LOCK <= lock_q;
         // Pulses while running, retained verdict otherwise
         O_PASS <= (ps_q == PS_IDLE || ps_q == PS_HIGH) ? (pass_q | bist_req) : 1'b0;
         // Start command over the back channel
         O_BIST_CMD <= bist_req;
         O_BIST_OSC <= sbw_osc_sel_type'(osc_sel);
         O_EXT_PCLK_REQ <= bist_req & (osc_sel == OSC_EXTERNAL);
         O_WAKE_SIGNAL <= wake_q;
         // Sleep output enable follows output state select; strobe held low
         O_RX_OE <= lock_q | gen_cfg_q[`SBW_BIT_OSS];
         O_RX_STROBE <= lock_q & (gen_cfg_q[`SBW_BIT_RX_EDGE] ? link_clk : ~link_clk);
         O_SER_ACTIVE <= (ser_q == SER_ACTIVE);
         // Pixel clock when present, else oscillator
         O_SER_CLK_FROM_PCLK <= (ser_q == SER_ACTIVE) & pclk_ok_q;
         O_SER_TX_STATIC_HIGH <= (ser_q == SER_STANDBY);
         O_SER_LATCH_RISE <= gen_cfg_q[`SBW_BIT_TX_EDGE];
         // Pass flag on serializer pin 0
         O_SER_GPIO0_OUT <= pass_q;
         O_SER_GPIO0_OE <= bist_req & (ser_q == SER_ACTIVE);
      end
   end

   // Registered read data; unmapped offsets read zero
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_REG_RDATA <= '0;
      end else begin
         case (I_REG_ADDR)
            `SBW_REG_GEN_CFG: O_REG_RDATA <= gen_cfg_q;
            `SBW_REG_BC_MODE: O_REG_RDATA <= bc_mode_q;
            `SBW_REG_BC_CFG: O_REG_RDATA <= bc_cfg_q;
            `SBW_REG_STATUS: O_REG_RDATA <= {3'b000, bist_req, ovf_q,
                                             ser_q == SER_ACTIVE, lock_q, pass_q};
            `SBW_REG_ERR_CNT: O_REG_RDATA <= 8'(err_cnt_q);
            default: O_REG_RDATA <= 8'h00;
         endcase
      end
   end
endmodule // sbw_link_maint

// ---- verification/sbw_link_maint_sva.sv ----
// Purpose: Port-level checks of the link upkeep block
// Assumes: One clock domain, I_NRST async active low
// Notes: Bound to sbw_link_maint after the module
`timescale 1ns/100ps
`include "sbw_consts.svh"
module sbw_link_maint_chk
   import sbw_pkg::*;
#(
   parameter int DATA_W = 16
) (
   input wire logic I_SYS_CLK,
   input wire logic I_NRST,
   input wire logic I_DES_MODE,
   input wire logic I_SER_MODE,
   input wire logic I_SELF_TEST_ENABLE_PIN,
   input wire logic I_LINK_CLK,
   input wire logic [7:0] I_REG_ADDR,
   input wire logic I_REG_WR,
   input wire logic [7:0] I_REG_WDATA,
   input wire logic I_RX_READY,
   input wire logic O_LOCK,
   input wire logic O_PASS,
   input wire logic O_BIST_CMD,
   input wire sbw_osc_sel_type O_BIST_OSC,
   input wire logic O_EXT_PCLK_REQ,
   input wire logic [DATA_W-1:0] O_RX_DATA,
   input wire logic O_RX_VALID,
   input wire logic O_RX_OE,
   input wire logic O_RX_STROBE,
   input wire logic O_SER_ACTIVE,
   input wire logic O_SER_CLK_FROM_PCLK,
   input wire logic O_SER_TX_STATIC_HIGH,
   input wire logic O_SER_GPIO0_OE
);
   // Margin over the loss count for the two sync stages
   localparam int LOSS_MAX = `SBW_LOSS_CYC + 10;
   logic lclk_q; // Last link clock sample
   logic [7:0] idle_q; // Cycles without link clock change, saturating
   logic oss_q; // Mirror of the sleep output select bit
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_NRST);
   // Idle counter saturates so it never wraps under the bound
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         lclk_q <= 1'b0;
         idle_q <= 8'h00;
      end else begin
         lclk_q <= I_LINK_CLK;
         if (I_LINK_CLK != lclk_q) idle_q <= 8'h00;
         else if (idle_q != 8'hff) idle_q <= idle_q + 8'h01;
      end
   end
   // Follows writes of the general configuration register
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) oss_q <= 1'b0;
      else if (I_REG_WR && I_REG_ADDR == `SBW_REG_GEN_CFG) oss_q <= I_REG_WDATA[`SBW_BIT_OSS];
   end
   // Enable pin held high in camera set-up for three cycles
   sequence s_start;
      $rose(I_SELF_TEST_ENABLE_PIN) ##0 (I_SELF_TEST_ENABLE_PIN && I_DES_MODE && !I_SER_MODE) [*3];
   endsequence
   // One failure pulse of ten cycles low
   sequence s_low10;
      (!O_PASS) [*8] ##1 (!O_PASS) [*2];
   endsequence
   AST_BIST_START: assert property (s_start |=> O_BIST_CMD)
      else $error("self test command not raised in time");
   AST_BIST_CAMERA: assert property ($rose(O_BIST_CMD) |->
      $past(I_SELF_TEST_ENABLE_PIN, 3) && $past(I_DES_MODE, 3)) else $error("test outside camera mode");
   AST_EXT_OSC: assert property (O_BIST_CMD && $past(O_BIST_CMD) && O_BIST_OSC == OSC_EXTERNAL
      |-> O_EXT_PCLK_REQ) else $error("external clock not requested");
   AST_FAIL_PULSE: assert property ($fell(O_PASS) |-> s_low10)
      else $error("failure pulse too short");
   AST_STATIC_HIGH: assert property ($stable(O_SER_ACTIVE) |-> O_SER_TX_STATIC_HIGH != O_SER_ACTIVE)
      else $error("driver static state wrong");
   AST_PCLK_SRC: assert property (O_SER_CLK_FROM_PCLK |-> O_SER_ACTIVE)
      else $error("pixel clock used while in standby");
   AST_GPIO0: assert property (O_SER_GPIO0_OE |-> O_SER_ACTIVE)
      else $error("pin 0 driven in standby");
   AST_LOCK_LOSS: assert property (idle_q >= LOSS_MAX |-> !O_LOCK)
      else $error("lock kept after stream stopped");
   AST_SLEEP_OE: assert property (!O_LOCK && !$past(O_LOCK) && $stable(oss_q) |-> O_RX_OE == oss_q)
      else $error("sleep output enable wrong");
   AST_STROBE_IDLE: assert property (!O_LOCK && !$past(O_LOCK) |-> !O_RX_STROBE)
      else $error("strobe toggles while unlocked");
   AST_RX_HOLD: assert property (O_RX_VALID && !I_RX_READY |=> O_RX_VALID && $stable(O_RX_DATA))
      else $error("held word lost");
endmodule // sbw_link_maint_chk

bind sbw_link_maint sbw_link_maint_chk #(.DATA_W(DATA_W)) u_chk (
   .I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST), .I_DES_MODE(I_DES_MODE), .I_SER_MODE(I_SER_MODE),
   .I_SELF_TEST_ENABLE_PIN(I_SELF_TEST_ENABLE_PIN), .I_LINK_CLK(I_LINK_CLK),
   .I_REG_ADDR(I_REG_ADDR), .I_REG_WR(I_REG_WR), .I_REG_WDATA(I_REG_WDATA),
   .I_RX_READY(I_RX_READY), .O_LOCK(O_LOCK), .O_PASS(O_PASS), .O_BIST_CMD(O_BIST_CMD),
   .O_BIST_OSC(O_BIST_OSC), .O_EXT_PCLK_REQ(O_EXT_PCLK_REQ), .O_RX_DATA(O_RX_DATA),
   .O_RX_VALID(O_RX_VALID), .O_RX_OE(O_RX_OE), .O_RX_STROBE(O_RX_STROBE),
   .O_SER_ACTIVE(O_SER_ACTIVE), .O_SER_CLK_FROM_PCLK(O_SER_CLK_FROM_PCLK),
   .O_SER_TX_STATIC_HIGH(O_SER_TX_STATIC_HIGH), .O_SER_GPIO0_OE(O_SER_GPIO0_OE)
);

// ---- verification/sbw_far_ser_model.sv ----
// Purpose: Far serializer sending link clock and test pattern
// Assumes: 160 ns link period, unrelated to the system clock
// Notes: Pattern holds its seed until lock is seen
`timescale 1ns/100ps
`include "sbw_consts.svh"
module sbw_far_ser_model (
   input wire logic i_run,
   input wire logic i_lock,
   input wire logic i_err_tgl,
   input wire logic i_err_two,
   output logic o_link_clk,
   output logic [15:0] o_link_data
);
   logic [14:0] state; // Pattern generator
   logic seen; // Last error request served
   logic lock_seen; // Lock seen at this rise
   initial begin
      o_link_clk = 1'b0;
      o_link_data = 16'h0000;
      state = `SBW_PRBS_SEED;
      seen = 1'b0;
      #3;
      forever begin
         if (i_run) begin
            o_link_data = {1'b0, state};
            // One corrupted payload per request
            if (seen != i_err_tgl) o_link_data = o_link_data ^ (i_err_two ? 16'h0005 : 16'h0001);
            seen = i_err_tgl;
            #80 o_link_clk = 1'b1;
            lock_seen = i_lock;
            #80 o_link_clk = 1'b0;
            if (lock_seen) repeat (16) state = {state[13:0], state[14] ^ state[13]};
         end else begin
            state = `SBW_PRBS_SEED;
            o_link_data = ~o_link_data;
            #160;
         end
      end
   end
endmodule // sbw_far_ser_model

// ---- verification/sbw_link_maint_tb.sv ----
// Purpose: Self-checking bench of the link upkeep block
// Assumes: 125 MHz clock, far side in sbw_far_ser_model
// Notes: Register port is a byte port with one-cycle read
`timescale 1ns/100ps
`include "sbw_consts.svh"
module sbw_link_maint_tb;
   import sbw_pkg::*;
   logic clk, nrst, des_mode, ser_mode, ser_pdb, en, wr, rx_ready, pclk, pclk_on, run;
   logic err_tgl, err_two, lclk, lock, pass, cmd, ext_req, rx_valid, rx_oe, strobe;
   logic act, from_pclk, st_high, latch_rise, g0, g0_oe, wake;
   logic [1:0] osc;
   logic [2:0] pcnt;
   logic [7:0] addr, wdata, rdata;
   logic [15:0] link_data, rx_data;
   sbw_osc_sel_type bosc;
   int fails, comparisons, cyc, n;
   sbw_link_maint DUT (.I_SYS_CLK(clk), .I_NRST(nrst), .I_DES_MODE(des_mode),
      .I_SER_MODE(ser_mode), .I_SER_PDB(ser_pdb), .I_SELF_TEST_ENABLE_PIN(en),
      .I_OSC_SEL_PIN(osc), .I_LINK_CLK(lclk), .I_LINK_DATA(link_data), .I_SER_PCLK(pclk),
      .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata), .I_RX_READY(rx_ready),
      .O_REG_RDATA(rdata), .O_LOCK(lock), .O_PASS(pass), .O_BIST_CMD(cmd), .O_BIST_OSC(bosc),
      .O_EXT_PCLK_REQ(ext_req), .O_WAKE_SIGNAL(wake), .O_RX_DATA(rx_data), .O_RX_VALID(rx_valid),
      .O_RX_OE(rx_oe), .O_RX_STROBE(strobe), .O_SER_ACTIVE(act), .O_SER_CLK_FROM_PCLK(from_pclk),
      .O_SER_TX_STATIC_HIGH(st_high), .O_SER_LATCH_RISE(latch_rise), .O_SER_GPIO0_OUT(g0),
      .O_SER_GPIO0_OE(g0_oe));
   sbw_far_ser_model FAR (.i_run(run), .i_lock(lock), .i_err_tgl(err_tgl), .i_err_two(err_two),
      .o_link_clk(lclk), .o_link_data(link_data));
   // System clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Pixel clock, stops where it stands when switched off
   always @(posedge clk) begin
      pcnt <= pcnt + 3'h1;
      if (pclk_on) pclk <= pcnt[2];
   end
   // Hang guard above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         final_report;
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // One-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      wt(2);
      chk(rdata, exp);
   endtask
   // Bounded waits on lock and on the result pin
   task automatic wait_lock(input logic v);
      n = 0;
      while (lock !== v && n < 4000) begin
         wt(1);
         n++;
      end
      chk(lock, v);
   endtask
   task automatic seek(input logic v);
      n = 0;
      while (pass !== v && n < 300) begin
         wt(1);
         n++;
      end
   endtask
   task automatic lvl(input logic v);
      n = 0;
      while (pass === v && n < 60) begin
         wt(1);
         n++;
      end
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   // Kind 0 clean, 1 one bad bit, 2 two bad bits
   task automatic session(input logic [1:0] code, input int kind);
      @(posedge clk);
      osc <= code;
      en <= 1'b1;
      run <= 1'b1;
      wt(5);
      chk(cmd, 1'b1);
      chk(bosc, code);
      chk(ext_req, code == 2'b00);
      rd(`SBW_REG_ERR_CNT, 8'h00);
      wait_lock(1'b1);
      wt(200);
      chk(g0_oe, 1'b1);
      chk(pass, 1'b1);
      if (kind > 0) begin
         err_two <= (kind == 2);
         err_tgl <= ~err_tgl;
         seek(1'b0);
         lvl(1'b0);
         chk(n[15:0], 16'h000a);
         if (kind == 2) begin
            lvl(1'b1);
            chk(n[15:0], 16'h000a);
            lvl(1'b0);
            chk(n[15:0], 16'h000a);
         end
         chk(g0, 1'b0);
      end
      rd(`SBW_REG_ERR_CNT, 8'(kind > 0));
      @(posedge clk);
      en <= 1'b0;
      wt(10);
      rd(`SBW_REG_STATUS, {5'h00, 2'b11, kind == 0});
      err_two <= 1'b0;
      err_tgl <= ~err_tgl;
      wt(100);
      rd(`SBW_REG_ERR_CNT, 8'(kind > 0));
      @(posedge clk);
      run <= 1'b0;
      wait_lock(1'b0);
      done("self test");
   endtask
   task final_report;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      {nrst, ser_mode, en, wr, pclk, pclk_on, run, err_tgl, err_two} = 9'h000;
      {des_mode, ser_pdb, rx_ready} = 3'h7;
      {osc, pcnt, addr, wdata} = 21'h000000;
      {fails, comparisons, cyc} = '0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      wt(1);
      chk(pass, 1'b1);
      chk(st_high, 1'b1);
      chk(act, 1'b0);
      rd(`SBW_REG_GEN_CFG, `SBW_GEN_CFG_RST);
      rd(`SBW_REG_BC_MODE, `SBW_BC_MODE_RST);
      rd(`SBW_REG_BC_CFG, `SBW_BC_CFG_RST);
      rd(8'h55, 8'h00);
      wr_reg(`SBW_REG_ERR_CNT, 8'hff);
      rd(`SBW_REG_ERR_CNT, 8'h00);
      done("reset");
      wr_reg(`SBW_REG_GEN_CFG, 8'h01);
      wt(3);
      chk(latch_rise, 1'b0);
      wr_reg(`SBW_REG_GEN_CFG, 8'h03);
      wt(3);
      chk(latch_rise, 1'b1);
      done("edge");
      @(posedge clk);
      ser_mode <= 1'b1;
      pclk_on <= 1'b1;
      wr_reg(`SBW_REG_BC_MODE, `SBW_BC_WAKE_MODE);
      wr_reg(`SBW_REG_GEN_CFG, 8'h07);
      wt(5);
      chk({act, wake}, 2'b01);
      @(posedge clk);
      ser_mode <= 1'b0;
      wt(5);
      chk(act, 1'b1);
      wr_reg(`SBW_REG_BC_MODE, 8'h00);
      wr_reg(`SBW_REG_BC_CFG, 8'hc0);
      wt(5);
      chk(act, 1'b1);
      chk(st_high, 1'b0);
      chk(from_pclk, 1'b1);
      @(posedge clk);
      pclk_on <= 1'b0;
      wt(200);
      chk(from_pclk, 1'b0);
      @(posedge clk);
      pclk_on <= 1'b1;
      wt(200);
      chk(from_pclk, 1'b1);
      done("wake");
      for (int i = 0; i < 4; i++) session(2'(i), i % 3);
      @(posedge clk);
      des_mode <= 1'b0;
      en <= 1'b1;
      wt(6);
      chk(cmd, 1'b0);
      @(posedge clk);
      en <= 1'b0;
      des_mode <= 1'b1;
      done("display mode");
      @(posedge clk);
      run <= 1'b1;
      rx_ready <= 1'b0;
      wait_lock(1'b1);
      wt(300);
      chk(rx_valid, 1'b1);
      chk(rx_data, `SBW_PRBS_SEED);
      rd(`SBW_REG_STATUS, 8'h0f);
      @(posedge clk);
      rx_ready <= 1'b1;
      wt(20);
      done("buffer");
      wr_reg(`SBW_REG_GEN_CFG, 8'h17);
      @(posedge clk);
      run <= 1'b0;
      wait_lock(1'b0);
      wt(4);
      chk(rx_oe, 1'b1);
      chk(strobe, 1'b0);
      wr_reg(`SBW_REG_GEN_CFG, 8'h03);
      wt(4);
      chk(rx_oe, 1'b0);
      chk(act, 1'b0);
      chk(st_high, 1'b1);
      @(posedge clk);
      run <= 1'b1;
      wait_lock(1'b1);
      wt(4);
      chk(rx_oe, 1'b1);
      done("sleep");
      final_report;
   end
endmodule // sbw_link_maint_tb
